// File: dv/ccb_ctrl_cfg_test.sv
/*
  ccb_ctrl_cfg_test.sv: self-checking bench for the control and configuration block.
  assumes: apb master below, other stations idle, engine flags driven as pulses.
*/
`timescale 1ns/10ps
`include "ccb_regs.svh"

module ccb_ctrl_cfg_test;
  import ccb_pkg::*;
  localparam int HB = 4;                           // short half bit for sim
  logic        clk_i, sys_rst_i, psel, pen, pwr, hold, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, cfg;
  logic [8:0]  ev;                                 // engine and receive pulses
  logic [3:0]  dest;
  logic        line, line_o, oe_n, tx_act, eom, acc, ack, errb, rxing, irq;
  int          mismatches, compares, n;
  int          halves [3] = '{10, 3, 15};          // free time per code below
  logic [2:0]  codes [3] = '{3'h0, 3'h1, 3'h7};
  logic [31:0] ecfg [5] = '{32'h00080000, 32'h00080040, 32'h00080010, 32'h00080090, 32'h80080000};
  logic [3:0]  edst [5] = '{4'h3, 4'h3, 4'hf, 4'hf, 4'hf};
  int          ekind [5] = '{7, 7, 6, 7, 8};
  logic        eexp [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};

  ccb_ctrl_cfg #(.HALF_BIT(HB)) u_ccb_ctrl_cfg (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr),
    .tx_end_i(ev[0]), .tx_underrun_i(ev[1]), .tx_ack_err_i(ev[2]), .tx_err_i(ev[3]),
    .arb_fail_i(ev[4]), .hdr_valid_i(ev[5]), .hdr_dest_i(dest),
    .rising_edge_error_i(ev[6]), .long_period_error_i(ev[7]), .short_period_error_i(ev[8]),
    .line_i(line), .line_o(line_o), .line_oe_n_o(oe_n),
    .tx_active_o(tx_act), .eom_value_o(eom), .rx_accept_o(acc), .rx_ack_o(ack),
    .err_bit_o(errb), .receiving_o(rxing), .cfg_o(cfg), .irq_o(irq)
  );

  ccb_line_peer u_ccb_line_peer (
    .drv_i(line_o), .drv_oe_n_i(oe_n), .hold_low_i(hold), .line_o(line)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock, 4 ns period
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // one apb transfer; waits for pready, takes data at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // one-cycle pulse on event k; outputs settled on return
  task automatic pulse(input int k, input logic [3:0] d);
    @(posedge clk_i);
    ev <= 9'h001 << k;
    dest <= d;
    @(posedge clk_i);
    ev <= 9'h000;
    #1;
  endtask

  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    sys_rst_i = 1'b1;
    {psel, pen, pwr, hold} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ev = 9'h000;
    dest = 4'h0;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    // reset values, unmapped place
    rdchk(`CCB_CTL_OFS, `CCB_CTL_RST);
    rdchk(`CCB_CFG_OFS, `CCB_CFG_RST);
    check(oe_n, 1'b1);
    check(line_o, 1'b0);
    check(pready, 1'b1);
    apb(1'b0, 12'h010, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    // start and end ignored while disabled
    wr(`CCB_CTL_OFS, 32'h6);
    rdchk(`CCB_CTL_OFS, 32'h0);
    // configuration only while disabled; option bit starts free time on enable
    wr(`CCB_CFG_OFS, 32'hffffffff);
    rdchk(`CCB_CFG_OFS, `CCB_CFG_WMASK);
    check(cfg, `CCB_CFG_WMASK);
    wr(`CCB_CTL_OFS, 32'h1);
    wr(`CCB_CFG_OFS, 32'h0);
    rdchk(`CCB_CFG_OFS, `CCB_CFG_WMASK);
    tick();
    check(rxing, 1'b0);
    wr(`CCB_CTL_OFS, 32'h0);
    tick();
    check(rxing, 1'b0);
    // free time per code, start bit, end flag clears both bits
    for (int i = 0; i < 3; i++) begin
      wr(`CCB_CFG_OFS, {29'h0, codes[i]});
      wr(`CCB_CTL_OFS, 32'h1);
      tick();
      check(rxing, 1'b1);
      wr(`CCB_CTL_OFS, 32'h7);
      n = 0;
      while (oe_n === 1'b1 && n < 200) begin
        @(posedge clk_i);
        n++;
      end
      check(n >= halves[i] * HB - 2 && n <= halves[i] * HB + 6, 1'b1);
      rdchk(`CCB_CTL_OFS, 32'h7);
      check({tx_act, eom}, 2'b11);
      pulse(0, 4'h0);
      rdchk(`CCB_CTL_OFS, 32'h1);
      check(eom, 1'b0);
      wr(`CCB_CTL_OFS, 32'h0);
    end
    // the underrun, ack error and error flags clear start and end
    wr(`CCB_CTL_OFS, 32'h1);
    for (int k = 1; k < 4; k++) begin
      wr(`CCB_CTL_OFS, 32'h5);
      rdchk(`CCB_CTL_OFS, 32'h5);
      wr(`CCB_CTL_OFS, 32'h7);
      pulse(k, 4'h0);
      rdchk(`CCB_CTL_OFS, 32'h1);
    end
    // abort while sending, just after the start bit, by disabling
    wr(`CCB_CTL_OFS, 32'h7);
    n = 0;
    while (oe_n === 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    wr(`CCB_CTL_OFS, 32'h0);
    tick();
    rdchk(`CCB_CTL_OFS, 32'h0);
    check({tx_act, oe_n, rxing}, 3'b010);
    // interrupt: raise, clear, mask
    wr(`CCB_ISTAT_OFS, 32'h7);
    wr(`CCB_IMASK_OFS, 32'h1);
    wr(`CCB_CTL_OFS, 32'h1);
    wr(`CCB_CTL_OFS, 32'h3);
    pulse(0, 4'h0);
    tick();
    check(irq, 1'b1);
    rdchk(`CCB_ISTAT_OFS, 32'h1);
    wr(`CCB_ISTAT_OFS, 32'h1);
    tick();
    check(irq, 1'b0);
    wr(`CCB_IMASK_OFS, 32'h0);
    wr(`CCB_CTL_OFS, 32'h3);
    pulse(0, 4'h0);
    tick();
    check(irq, 1'b0);
    rdchk(`CCB_ISTAT_OFS, 32'h1);
    // own address filter, without and with listen mode
    wr(`CCB_CTL_OFS, 32'h0);
    wr(`CCB_CFG_OFS, 32'h00080000);
    wr(`CCB_CTL_OFS, 32'h1);
    pulse(5, 4'h3);
    check({acc, ack}, 2'b11);
    pulse(5, 4'h5);
    check(acc, 1'b0);
    pulse(5, 4'hf);
    check(acc, 1'b1);
    wr(`CCB_CTL_OFS, 32'h0);
    wr(`CCB_CFG_OFS, 32'h80080000);
    wr(`CCB_CTL_OFS, 32'h1);
    pulse(5, 4'h5);
    check({acc, ack}, 2'b10);
    pulse(5, 4'h3);
    check({acc, ack}, 2'b11);
    // error bit decisions, table driven
    for (int i = 0; i < 5; i++) begin
      wr(`CCB_CTL_OFS, 32'h0);
      wr(`CCB_CFG_OFS, ecfg[i]);
      wr(`CCB_CTL_OFS, 32'h1);
      pulse(5, edst[i]);
      pulse(ekind[i], edst[i]);
      check(errb, eexp[i]);
    end
    stop_test();
  end
endmodule // ccb_ctrl_cfg_test

// File: dv/ccb_line_peer.sv
/*
  ccb_line_peer.sv: the other stations on the open-drain control bus line.
  assumes: a pull-up holds the line high unless some station pulls it low.
*/
`timescale 1ns/10ps

module ccb_line_peer (
  // our station's pin
  input  wire logic drv_i,
  input  wire logic drv_oe_n_i,
  // other stations
  input  wire logic hold_low_i,
  output logic      line_o
);
  // wired-and: any low driver wins, else the pull-up
  assign line_o = ~((~drv_oe_n_i & ~drv_i) | hold_low_i);
endmodule // ccb_line_peer

// File: logic/ccb_ctrl_cfg.sv
/*
  ccb_ctrl_cfg.sv: control and configuration registers of a single-wire control bus
  controller, its start sequencer, address filter and error-bit decisions.
  assumes: apb master on clk_i; bit timing, arbitration and error detectors outside
  report end and error flags and header addresses as one-cycle pulses on clk_i.
*/
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
`include "ccb_regs.svh"

module ccb_ctrl_cfg (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // transmit engine flags, one-cycle pulses
  input  wire logic        tx_end_i,
  input  wire logic        tx_underrun_i,
  input  wire logic        tx_ack_err_i,
  input  wire logic        tx_err_i,
  input  wire logic        arb_fail_i,
  // receive side events, one-cycle pulses
  input  wire logic        hdr_valid_i,
  input  wire logic [3:0]  hdr_dest_i,
  input  wire logic        rising_edge_error_i,
  input  wire logic        long_period_error_i,
  input  wire logic        short_period_error_i,
  // bus line, open drain
  input  wire logic        line_i,
  output logic             line_o,
  output logic             line_oe_n_o,
  // decisions for the framing logic
  output logic             tx_active_o,
  output logic             eom_value_o,
  output logic             rx_accept_o,
  output logic             rx_ack_o,
  output logic             err_bit_o,
  output logic             receiving_o,
  output logic [31:0]      cfg_o,
  // interrupt
  output logic             irq_o
);
  import ccb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // constants
  localparam int HALF_BIT_CYC = `CCB_HALF_BIT_US * `CCB_CLK_MHZ;  // half bit in clocks
  parameter int unsigned HALF_BIT = HALF_BIT_CYC;                  // shortened in sim
  localparam logic [3:0] BCAST = 4'hf;                              // broadcast address

  ////////////////////////////////////////////////////////////////////////////////
  // registers and state
  logic        en_q;             // controller enable
  logic        start_q;          // send message start
  logic        eom_q;            // end of message value
  logic [31:0] cfg_q;            // configuration word
  logic [`CCB_IRQ_W-1:0] ist_q;  // sticky interrupt status
  logic [`CCB_IRQ_W-1:0] imsk_q; // interrupt mask
  ccb_state_t  st_q;             // sequencer state
  ccb_sft_t    why_q;            // reason free time started
  logic [19:0] half_q;           // half bit period timer
  logic [3:0]  halves_q;         // half periods counted
  logic [3:0]  need_d;           // half periods needed
  logic        line_s1_q;        // synchroniser first stage
  logic        line_s2_q;        // synchronised line
  logic        bcast_q;          // current message broadcast
  logic        err_q;            // error bit request
  logic        hdr_own_d;        // destination owned

  // bus decode
  logic wr_en;
  logic rd_en;
  logic tx_stop;
  logic sft_done;
  logic [31:0] rd_d;
  logic [`CCB_IRQ_W-1:0] ev_d;

  assign wr_en   = psel_i && penable_i && pwrite_i;
  assign rd_en   = psel_i && penable_i && !pwrite_i;
  assign tx_stop = tx_end_i || tx_underrun_i || tx_ack_err_i || tx_err_i;

  ////////////////////////////////////////////////////////////////////////////////
  // enable bit
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      en_q <= 1'b0;
    end else if (wr_en && paddr_i == `CCB_CTL_OFS && pstrb_i[0]) begin
      en_q <= pwdata_i[`CCB_CTL_EN_BIT];
    end
  end

  // start and end bits: set only when enabled, cleared by hardware
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      start_q <= 1'b0;
      eom_q   <= 1'b0;
    end else if (!en_q || tx_stop) begin
      start_q <= 1'b0;
      eom_q   <= 1'b0;
    end else if (wr_en && paddr_i == `CCB_CTL_OFS && pstrb_i[0]) begin
      // software writes of zero are ignored; engine stop flags or disabling clear
      if (pwdata_i[`CCB_CTL_START_BIT]) begin
        start_q <= 1'b1;
      end
      if (pwdata_i[`CCB_CTL_EOM_BIT]) begin
        eom_q <= 1'b1;
      end
    end
  end

  // configuration: writes take effect only while disabled
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg_q <= `CCB_CFG_RST;
    end else if (wr_en && paddr_i == `CCB_CFG_OFS && !en_q) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb_i[b]) begin
          cfg_q[b*8 +: 8] <= pwdata_i[b*8 +: 8] & 8'(`CCB_CFG_WMASK >> (b*8));
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer: off, receiving, free time, sending
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q  <= CCB_OFF;
      why_q <= CCB_SFT_NEW;
    end else if (!en_q) begin
      st_q <= CCB_OFF;
    end else begin
      unique case (st_q)
        CCB_OFF: begin
          // free time may start at enable when the option is set
          st_q <= cfg_q[`CCB_CFG_FREE_TIME_START_OPTION_BIT] ? CCB_WAIT : CCB_RX;
          why_q <= CCB_SFT_NEW;
        end
        CCB_RX: begin
          if (start_q) begin
            st_q <= CCB_WAIT;
          end
        end
        CCB_WAIT: begin
          if (!start_q && !cfg_q[`CCB_CFG_FREE_TIME_START_OPTION_BIT]) begin
            st_q <= CCB_RX;
          end else if (sft_done && start_q) begin
            st_q <= CCB_SEND;
          end
        end
        CCB_SEND: begin
          if (tx_stop || arb_fail_i) begin
            st_q  <= cfg_q[`CCB_CFG_FREE_TIME_START_OPTION_BIT] ? CCB_WAIT : CCB_RX;
            why_q <= tx_end_i ? CCB_SFT_OK : CCB_SFT_FAIL;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // free time length in half bit periods
  always_comb begin
    need_d = 4'h0;
    if (cfg_q[`CCB_CFG_SFT_MSB:`CCB_CFG_SFT_LSB] == 3'h0) begin
      unique case (why_q)
        CCB_SFT_FAIL: need_d = 4'h6;
        CCB_SFT_NEW:  need_d = 4'ha;
        default:      need_d = 4'he;
      endcase
    end else begin
      need_d = {cfg_q[`CCB_CFG_SFT_MSB:`CCB_CFG_SFT_LSB], 1'b1};
    end
  end

  // free time timer restarts whenever the line is low or not waiting
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || st_q != CCB_WAIT || !line_s2_q) begin
      half_q   <= 20'h00000;
      halves_q <= 4'h0;
    end else if (!sft_done) begin
      if (half_q == 20'(HALF_BIT - 1)) begin
        half_q   <= 20'h00000;
        halves_q <= halves_q + 4'h1;
      end else begin
        half_q <= half_q + 20'h00001;
      end
    end
  end
  assign sft_done = halves_q >= need_d;

  // line synchroniser
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      line_s1_q <= 1'b1;
      line_s2_q <= 1'b1;
    end else begin
      line_s1_q <= line_i;
      line_s2_q <= line_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // address filter and error-bit decisions
  always_comb begin
    hdr_own_d = 1'b0;
    if (hdr_dest_i != BCAST) begin
      hdr_own_d = cfg_q[`CCB_CFG_OAD_LSB + hdr_dest_i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !en_q) begin
      rx_accept_o <= 1'b0;
      rx_ack_o    <= 1'b0;
      bcast_q     <= 1'b0;
    end else if (hdr_valid_i) begin
      bcast_q     <= hdr_dest_i == BCAST;
      // owned or broadcast accepted; listen takes the rest silently
      rx_accept_o <= hdr_own_d || hdr_dest_i == BCAST || cfg_q[`CCB_CFG_LISTEN_BIT];
      rx_ack_o    <= hdr_own_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      err_q <= 1'b0;
    end else if (bcast_q) begin
      err_q <= !cfg_q[`CCB_CFG_BCSUP_BIT] && (rising_edge_error_i || long_period_error_i
               || (short_period_error_i && cfg_q[`CCB_CFG_LISTEN_BIT]));
    end else begin
      err_q <= long_period_error_i && cfg_q[`CCB_CFG_LPEG_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupts: set wins over write-one clear
  assign ev_d = {err_q, tx_ack_err_i | tx_err_i | tx_underrun_i, tx_end_i};
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ist_q  <= '0;
      imsk_q <= '0;
    end else begin
      if (wr_en && paddr_i == `CCB_IMASK_OFS && pstrb_i[0]) begin
        imsk_q <= pwdata_i[`CCB_IRQ_W-1:0];
      end
      if (wr_en && paddr_i == `CCB_ISTAT_OFS && pstrb_i[0]) begin
        ist_q <= (ist_q & ~pwdata_i[`CCB_IRQ_W-1:0]) | ev_d;
      end else begin
        ist_q <= ist_q | ev_d;
      end
    end
  end
  assign irq_o = |(ist_q & imsk_q);

  ////////////////////////////////////////////////////////////////////////////////
  // read mux and registered read data
  always_comb begin
    rd_d = 32'h00000000;
    unique case (paddr_i)
      `CCB_CTL_OFS:   rd_d = {29'h0, eom_q, start_q, en_q};
      `CCB_CFG_OFS:   rd_d = cfg_q;
      `CCB_ISTAT_OFS: rd_d = {29'h0, ist_q};
      `CCB_IMASK_OFS: rd_d = {29'h0, imsk_q};
      default:        rd_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h00000000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= rd_d;
    end
  end

  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && paddr_i != `CCB_CTL_OFS && paddr_i != `CCB_CFG_OFS
                     && paddr_i != `CCB_ISTAT_OFS && paddr_i != `CCB_IMASK_OFS;

  // outputs to framing logic; line driven low only for the start bit here
  assign tx_active_o = st_q == CCB_SEND;
  assign eom_value_o = eom_q;
  assign receiving_o = st_q == CCB_RX;
  assign err_bit_o   = err_q;
  assign cfg_o       = cfg_q;
  assign line_o      = 1'b0;
  assign line_oe_n_o = !(st_q == CCB_WAIT && sft_done && start_q);

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  start_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (tx_stop || !en_q) |=> !start_q && !eom_q) else $error("start not cleared");
  eom_like_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(start_q) |-> !eom_q) else $error("end bit outlived start");
  set_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(start_q) |-> $past(en_q)) else $error("start set while disabled");
  abort_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !en_q |=> st_q == CCB_OFF) else $error("disable did not abort");
  pending_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tx_active_o |-> start_q || $past(start_q)) else $error("sending without start");
  cfg_lock_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $past(en_q) && en_q |-> $stable(cfg_q)) else $error("config changed while enabled");
  ack_own_a: assert property (@(posedge clk_i) disable iff (sys_rst_i || !en_q)
    hdr_valid_i && hdr_dest_i != BCAST |=> rx_ack_o == $past(hdr_own_d)) else $error("ack wrong");
  lp_err_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !bcast_q && long_period_error_i |=> err_q == $past(cfg_q[`CCB_CFG_LPEG_BIT]))
    else $error("long period error bit wrong");
  bc_sup_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    bcast_q && cfg_q[`CCB_CFG_BCSUP_BIT] |=> !err_q) else $error("suppressed error bit driven");
endmodule // ccb_ctrl_cfg

// File: logic/ccb_pkg.sv
/*
  ccb_pkg.sv: types shared by the control bus controller register block.
  assumes: nothing beyond the header of constants.
*/
package ccb_pkg;
  // transmit sequencer states
  typedef enum logic [1:0] {
    CCB_OFF  = 2'b00,  // controller disabled
    CCB_RX   = 2'b01,  // receiving state
    CCB_WAIT = 2'b10,  // counting signal free time
    CCB_SEND = 2'b11   // start bit sent, line released, frames going out
  } ccb_state_t;

  // reason the free time counter was started
  typedef enum logic [1:0] {
    CCB_SFT_FAIL = 2'b00,  // after failed transfer
    CCB_SFT_NEW  = 2'b01,  // as new initiator
    CCB_SFT_OK   = 2'b10   // after successful transfer
  } ccb_sft_t;
endpackage

// File: logic/ccb_regs.svh
/*
  ccb_regs.svh: register offsets, field positions, reset values and timing counts
  for the control bus controller register block.
  assumes: included by bare name from the test bench and the design file.
*/
`ifndef CCB_REGS_SVH
`define CCB_REGS_SVH

// register byte offsets
`define CCB_CTL_OFS        12'h000
`define CCB_CFG_OFS        12'h004
`define CCB_ISTAT_OFS      12'h008
`define CCB_IMASK_OFS      12'h00c

// control field positions
`define CCB_CTL_EN_BIT     0
`define CCB_CTL_START_BIT  1
`define CCB_CTL_EOM_BIT    2

// configuration field positions
`define CCB_CFG_SFT_LSB    0
`define CCB_CFG_SFT_MSB    2
`define CCB_CFG_RTOL_BIT   3
`define CCB_CFG_BRES_BIT   4
`define CCB_CFG_BREG_BIT   5
`define CCB_CFG_LPEG_BIT   6
`define CCB_CFG_BCSUP_BIT  7
`define CCB_CFG_FREE_TIME_START_OPTION_BIT 8
`define CCB_CFG_OAD_LSB    16
`define CCB_CFG_OAD_MSB    30
`define CCB_CFG_LISTEN_BIT 31
`define CCB_CFG_WMASK      32'hffff01ff

// reset values
`define CCB_CTL_RST        32'h00000000
`define CCB_CFG_RST        32'h00000000

// interrupt status bit positions
`define CCB_IRQ_DONE_BIT   0
`define CCB_IRQ_FAIL_BIT   1
`define CCB_IRQ_ERRB_BIT   2
`define CCB_IRQ_W          3

// timing: nominal data bit period 2.4 ms, half a period counted in clocks
`define CCB_CLK_MHZ        250
`define CCB_HALF_BIT_US    1200

`endif
